// ===== common/tpw_pkg.sv
// ==========================================================
// shared constants and types of the pulse width timer
package tpw_pkg;

	// ==========================================================
	// register offsets (byte addresses)
	localparam logic [7:0] OFS_MODE_MEAS    = 8'h00;
	localparam logic [7:0] OFS_START        = 8'h04;
	localparam logic [7:0] OFS_STOP         = 8'h08;
	localparam logic [7:0] OFS_ENABLED      = 8'h0C;
	localparam logic [7:0] OFS_DATA         = 8'h10;
	localparam logic [7:0] OFS_STATUS       = 8'h14;
	localparam logic [7:0] OFS_COUNTER      = 8'h18;
	localparam logic [7:0] OFS_MODE_SLAVE   = 8'h1C;
	localparam logic [7:0] OFS_SLAVE_DATA   = 8'h20;
	localparam logic [7:0] OFS_SLAVE_COUNT  = 8'h24;
	localparam logic [7:0] OFS_OUT_LEVEL    = 8'h28;
	localparam logic [7:0] OFS_OUT_ENABLE   = 8'h2C;
	localparam logic [7:0] OFS_OUT_POLARITY = 8'h30;
	localparam logic [7:0] OFS_OUT_MODE     = 8'h34;
	localparam logic [7:0] OFS_PRESCALE     = 8'h38;

	// ==========================================================
	// field positions
	localparam int BIT_MEAS      = 0;
	localparam int BIT_SLAVE     = 1;
	localparam int BIT_OVERFLOW  = 0;
	localparam int PRESC_ZERO_LO = 0;
	localparam int PRESC_ONE_LO  = 4;

	// ==========================================================
	// encodings
	localparam logic [1:0] EDGE_LOW_WIDTH  = 2'b10;
	localparam logic [1:0] EDGE_HIGH_WIDTH = 2'b11;
	localparam logic [1:0] CKSEL_ZERO      = 2'b00;
	localparam logic [1:0] CKSEL_ONE       = 2'b10;
	localparam logic [2:0] MODE_ONE_COUNT  = 3'b100;
	localparam logic [2:0] TRIG_MASTER     = 3'b100;

	// ==========================================================
	// reset values and counter limits
	localparam logic [15:0] MODE_RST     = 16'h0000;
	localparam logic [15:0] WORD16_RST   = 16'h0000;
	localparam logic [7:0]  PRESCALE_RST = 8'h00;
	localparam logic [1:0]  BITS2_RST    = 2'b00;
	localparam logic [15:0] CNT_ZERO     = 16'h0000;
	localparam logic [15:0] CNT_FULL     = 16'hFFFF;
	localparam logic [15:0] CNT_ONE      = 16'h0001;

	// ==========================================================
	// channel mode register layout
	typedef struct packed {
		logic [1:0] clock_select_field;
		logic       rsv13;
		logic       count_clock_source_bit;
		logic       master_bit;
		logic [2:0] trigger_source_field;
		logic       edge_select_high_bit;
		logic       edge_select_low_bit;
		logic [1:0] rsv5_4;
		logic [2:0] operation_mode_field;
		logic       retrigger_bit;
	} tpw_mode_t;

	// measurement channel states
	typedef enum logic [1:0] {
		TPW_IDLE,
		TPW_WAIT_START,
		TPW_COUNTING
	} tpw_state_t;

endpackage : tpw_pkg

// ===== hdl/tpw_timer.sv
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
// What this block does
// - start bit enables channel, waits start edge
// - up counter from zero after start edge
// - capture edge copies count, raises done
// - overflow flag updated at every capture
// - counter stops at capture plus one, rearms
// - many wraps still give single overflow flag
// - edge select 10B low, 11B high width
// - start ignored while channel already enabled
// - pin sampled on selected operating clock tick
// - width equals period times overflow-extended count plus one
// - slave one-count mode, optional retrigger
// - trigger source 100B uses master done
// - clock select 00B zero, 10B one
// - output level bit drives pin level
// - output enable with output mode lets slave counting drive output 1
// - polarity bit inverts output when one
// - output mode bit selects slave output
module tpw_timer
	import tpw_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        timer_input_pin,
	output logic      [1:0]  timer_output_pin,
	output logic      [1:0]  channel_done_irq
);
	// ==========================================================
	// apb decode
	logic        acc;
	logic        wr;
	logic        mapped;
	logic [15:0] wdata16;
	assign acc     = psel & penable;
	assign wr      = acc & pwrite;
	assign pready  = acc;
	assign pslverr = acc & ~mapped;
	// merge write data with byte strobes
	function automatic logic [15:0] merge16(input logic [15:0] old);
		logic [15:0] v;
		v = old;
		if (pstrb[0]) begin
			v[7:0] = pwdata[7:0];
		end
		if (pstrb[1]) begin
			v[15:8] = pwdata[15:8];
		end
		return v;
	endfunction : merge16
	// address map check
	always_comb begin
		case (paddr)
			OFS_MODE_MEAS, OFS_START, OFS_STOP, OFS_ENABLED, OFS_DATA,
			OFS_STATUS, OFS_COUNTER, OFS_MODE_SLAVE, OFS_SLAVE_DATA,
			OFS_SLAVE_COUNT, OFS_OUT_LEVEL, OFS_OUT_ENABLE,
			OFS_OUT_POLARITY, OFS_OUT_MODE, OFS_PRESCALE: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end
	// ==========================================================
	// software registers
	tpw_mode_t   mode_meas;
	tpw_mode_t   mode_slave;
	logic [15:0] slave_data;
	logic [1:0]  out_enable;
	logic [1:0]  out_polarity;
	logic [1:0]  out_mode;
	logic [7:0]  prescale;
	logic        wr_start;
	logic        wr_stop;
	assign wdata16  = pwdata[15:0];
	assign wr_start = wr & (paddr == OFS_START);
	assign wr_stop  = wr & (paddr == OFS_STOP);
	// configuration writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_meas    <= MODE_RST;
			mode_slave   <= MODE_RST;
			slave_data   <= WORD16_RST;
			out_enable   <= BITS2_RST;
			out_polarity <= BITS2_RST;
			out_mode     <= BITS2_RST;
			prescale     <= PRESCALE_RST;
		end else if (wr) begin
			case (paddr)
				OFS_MODE_MEAS:    mode_meas    <= merge16(mode_meas);
				OFS_MODE_SLAVE:   mode_slave   <= merge16(mode_slave);
				OFS_SLAVE_DATA:   slave_data   <= merge16(slave_data);
				OFS_OUT_ENABLE:   out_enable   <= wdata16[1:0];
				OFS_OUT_POLARITY: out_polarity <= wdata16[1:0];
				OFS_OUT_MODE:     out_mode     <= wdata16[1:0];
				OFS_PRESCALE:     prescale     <= pwdata[7:0];
				default: ;
			endcase
		end
	end
	// ==========================================================
	// prescaler and operating clock ticks
	logic [15:0] presc_cnt;
	logic [15:0] mask_zero;
	logic [15:0] mask_one;
	logic        tick_zero;
	logic        tick_one;
	logic        tick_meas;
	logic        tick_slave;
	// free running divider chain
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc_cnt <= CNT_ZERO;
		end else begin
			presc_cnt <= presc_cnt + CNT_ONE;
		end
	end
	// divide by two to the selected power
	assign mask_zero = ~(CNT_FULL << prescale[PRESC_ZERO_LO +: 4]);
	assign mask_one  = ~(CNT_FULL << prescale[PRESC_ONE_LO +: 4]);
	assign tick_zero = (presc_cnt & mask_zero) == mask_zero;
	assign tick_one  = (presc_cnt & mask_one) == mask_one;
	assign tick_meas  = (mode_meas.clock_select_field == CKSEL_ONE) ? tick_one : tick_zero;
	assign tick_slave = (mode_slave.clock_select_field == CKSEL_ONE) ? tick_one : tick_zero;
	// ==========================================================
	// input pin synchroniser and sampling
	logic sync1;
	logic sync2;
	logic sync3;
	logic pin_level;
	logic pin_sample;
	logic rise;
	logic fall;
	logic start_edge;
	logic capture_edge;
	logic width_mode;
	// three stage synchroniser, level moves when stages two and three agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1     <= 1'b0;
			sync2     <= 1'b0;
			sync3     <= 1'b0;
			pin_level <= 1'b0;
		end else begin
			sync1 <= timer_input_pin;
			sync2 <= sync1;
			sync3 <= sync2;
			if (sync2 == sync3) begin
				pin_level <= sync3;
			end
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_sample <= 1'b0;
		end else if (tick_meas) begin
			pin_sample <= pin_level;
		end
	end
	assign rise       = tick_meas & pin_level & ~pin_sample;
	assign fall       = tick_meas & ~pin_level & pin_sample;
	assign width_mode = mode_meas.edge_select_high_bit;
	assign start_edge   = width_mode & (mode_meas.edge_select_low_bit ? rise : fall);
	assign capture_edge = width_mode & (mode_meas.edge_select_low_bit ? fall : rise);
	// ==========================================================
	// measurement channel
	tpw_state_t  state;
	logic [15:0] meas_counter;
	logic [15:0] meas_data;
	logic        meas_enabled;
	logic        overflow_flag;
	logic        overflow_pend;
	logic        meas_done;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meas_enabled <= 1'b0;
		end else if (wr_stop && pwdata[BIT_MEAS]) begin
			meas_enabled <= 1'b0;
		end else if (wr_start && pwdata[BIT_MEAS]) begin
			meas_enabled <= 1'b1;
		end
	end
	// sequence of wait, count and capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= TPW_IDLE;
		end else if (wr_stop && pwdata[BIT_MEAS]) begin
			state <= TPW_IDLE;
		end else begin
			case (state)
				TPW_IDLE: begin
					if (wr_start && pwdata[BIT_MEAS] && !meas_enabled) begin
						state <= TPW_WAIT_START;
					end
				end
				TPW_WAIT_START: begin
					if (start_edge) begin
						state <= TPW_COUNTING;
					end
				end
				TPW_COUNTING: begin
					if (capture_edge) begin
						state <= TPW_WAIT_START;
					end
				end
				default: state <= TPW_IDLE;
			endcase
		end
	end
	// counter behaviour per state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meas_counter <= CNT_ZERO;
		end else if (state == TPW_WAIT_START && start_edge) begin
			meas_counter <= CNT_ZERO;
		end else if (state == TPW_COUNTING && tick_meas) begin
			// capture step leaves value plus one
			meas_counter <= meas_counter + CNT_ONE;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			overflow_pend <= 1'b0;
		end else if (state == TPW_WAIT_START && start_edge) begin
			overflow_pend <= 1'b0;
		end else if (state == TPW_COUNTING && tick_meas && !capture_edge
			&& meas_counter == CNT_FULL) begin
			overflow_pend <= 1'b1;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meas_data <= CNT_ZERO;
		end else if (state == TPW_COUNTING && capture_edge) begin
			meas_data <= meas_counter;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			overflow_flag <= 1'b0;
		end else if (state == TPW_COUNTING && capture_edge) begin
			overflow_flag <= overflow_pend;
		end
	end
	assign meas_done = (state == TPW_COUNTING) & capture_edge;
	// ==========================================================
	// slave one-count channel
	logic [15:0] slave_counter;
	logic        slave_enabled;
	logic        slave_run;
	logic        slave_trig;
	logic        slave_accept;
	logic        slave_end;
	logic        slave_one_count;
	assign slave_one_count = mode_slave.operation_mode_field == MODE_ONE_COUNT;
	assign slave_trig = slave_enabled & slave_one_count
		& ((mode_slave.trigger_source_field == TRIG_MASTER) ? meas_done
			: (wr_start & pwdata[BIT_SLAVE]));
	assign slave_accept = slave_trig & (~slave_run | mode_slave.retrigger_bit);
	assign slave_end    = slave_run & tick_slave & ~slave_accept
		& (slave_counter == CNT_ZERO);
	// slave enable flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slave_enabled <= 1'b0;
		end else if (wr_stop && pwdata[BIT_SLAVE]) begin
			slave_enabled <= 1'b0;
		end else if (wr_start && pwdata[BIT_SLAVE]) begin
			slave_enabled <= 1'b1;
		end
	end

	// load, count down, stop past zero with full count loaded
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slave_counter <= CNT_ZERO;
			slave_run     <= 1'b0;
		end else if (wr_stop && pwdata[BIT_SLAVE]) begin
			slave_run <= 1'b0;
		end else if (slave_accept) begin
			slave_counter <= slave_data;
			slave_run     <= 1'b1;
		end else if (slave_end) begin
			slave_counter <= CNT_FULL;
			slave_run     <= 1'b0;
		end else if (slave_run && tick_slave) begin
			slave_counter <= slave_counter - CNT_ONE;
		end
	end
	// ==========================================================
	// timer outputs
	logic [1:0] out_level;
	logic       slave_drive;
	assign slave_drive = out_enable[BIT_SLAVE] & out_mode[BIT_SLAVE];
	// output level register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_level <= BITS2_RST;
		end else begin
			if (wr && paddr == OFS_OUT_LEVEL && !out_enable[BIT_MEAS]) begin
				out_level[BIT_MEAS] <= pwdata[BIT_MEAS];
			end
			if (slave_drive && slave_accept) begin
				out_level[BIT_SLAVE] <= 1'b1;
			end else if (slave_drive && slave_end) begin
				out_level[BIT_SLAVE] <= 1'b0;
			end else if (wr && paddr == OFS_OUT_LEVEL && !out_enable[BIT_SLAVE]) begin
				out_level[BIT_SLAVE] <= pwdata[BIT_SLAVE];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_output_pin <= BITS2_RST;
		end else begin
			timer_output_pin <= out_level ^ out_polarity;
		end
	end
	// done pulses, registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			channel_done_irq <= BITS2_RST;
		end else begin
			channel_done_irq <= {slave_end, meas_done};
		end
	end
	// ==========================================================
	// read data, latched in the setup phase
	logic [15:0] rd16;
	always_comb begin
		case (paddr)
			OFS_MODE_MEAS:    rd16 = mode_meas;
			OFS_ENABLED:      rd16 = {14'h0000, slave_enabled, meas_enabled};
			OFS_DATA:         rd16 = meas_data;
			OFS_STATUS:       rd16 = {15'h0000, overflow_flag};
			OFS_COUNTER:      rd16 = meas_counter;
			OFS_MODE_SLAVE:   rd16 = mode_slave;
			OFS_SLAVE_DATA:   rd16 = slave_data;
			OFS_SLAVE_COUNT:  rd16 = slave_counter;
			OFS_OUT_LEVEL:    rd16 = {14'h0000, out_level};
			OFS_OUT_ENABLE:   rd16 = {14'h0000, out_enable};
			OFS_OUT_POLARITY: rd16 = {14'h0000, out_polarity};
			OFS_OUT_MODE:     rd16 = {14'h0000, out_mode};
			OFS_PRESCALE:     rd16 = {8'h00, prescale};
			default:          rd16 = 16'h0000;
		endcase
	end

	// read word captured at setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable) begin
			prdata <= {16'h0000, rd16};
		end
	end

endmodule : tpw_timer

// ===== test/tpw_chk.sv
`timescale 1ns/1ps
// ==========
// port checks
module tpw_chk
	import tpw_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        timer_input_pin,
	input wire logic [1:0]  timer_output_pin,
	input wire logic [1:0]  channel_done_irq
);
	logic lvl0;
	logic pol0;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// shadow of measure output level and polarity
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lvl0 <= 1'b0;
			pol0 <= 1'b0;
		end else if (psel && penable && pwrite) begin
			if (paddr == OFS_OUT_LEVEL) lvl0 <= pwdata[0];
			if (paddr == OFS_OUT_POLARITY) pol0 <= pwdata[0];
		end
	end
	a_ready_zero_wait: assert property (psel && penable |-> pready)
		else $error("pready late");
	a_ready_idle: assert property (!(psel && penable) |-> !pready && !pslverr)
		else $error("pready outside access");
	a_err_unmapped: assert property (psel && penable && paddr > OFS_PRESCALE |-> pslverr)
		else $error("no error on unmapped");
	a_err_mapped: assert property (psel && penable && paddr <= OFS_PRESCALE
		&& paddr[1:0] == 2'b00 |-> !pslverr) else $error("error on mapped");
	a_rdata_upper: assert property (prdata[31:16] == 16'h0000)
		else $error("upper read data set");
	a_done_pulse: assert property (channel_done_irq[0] |=> !channel_done_irq[0])
		else $error("capture done not a pulse");
	a_slave_pulse: assert property (channel_done_irq[1] |=> !channel_done_irq[1])
		else $error("slave done not a pulse");
	a_out_level: assert property (timer_output_pin[0] == $past(lvl0 ^ pol0))
		else $error("measure output level wrong");
endmodule : tpw_chk

// ===== test/tpw_src.sv
`timescale 1ns/1ps
// ==========
// pulse source on the timer input
module tpw_src (
	input  wire logic pclk,
	output logic      pin
);
	initial pin = 1'b0;
	// idle level before a measurement
	task automatic park(input logic v);
		@(posedge pclk);
		pin <= v;
	endtask : park
	// one pulse of w clocks at level v
	task automatic pulse(input logic v, input int w);
		@(posedge pclk);
		pin <= v;
		repeat (w) @(posedge pclk);
		pin <= !v;
	endtask : pulse
endmodule : tpw_src

// ===== test/tb_top.sv
`timescale 1ns/1ps
// ==========
// bench top
module tb_top;
	import tpw_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, timer_input_pin;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb;
	logic [1:0]  timer_output_pin, channel_done_irq;
	logic        err, seen_hi;
	int          mismatches, checks_done, cycles;
	logic [7:0]  rst_a [6] = '{OFS_MODE_MEAS, OFS_DATA, OFS_STATUS, OFS_COUNTER,
		OFS_MODE_SLAVE, OFS_OUT_LEVEL};

	tpw_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .timer_input_pin(timer_input_pin),
		.timer_output_pin(timer_output_pin), .channel_done_irq(channel_done_irq));
	tpw_src u_src (.pclk(pclk), .pin(timer_input_pin));

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	// hang limit and slave output watch
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (timer_output_pin[1] === 1'b1) seen_hi <= 1'b1;
		if (cycles == 80000) begin
			mismatches++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : stop_test
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask : rdchk
	task automatic wait_irq(input int b, input int lim);
		int i;
		for (i = 0; i < lim && channel_done_irq[b] !== 1'b1; i++) @(posedge pclk);
		chk("irq", 32'h1, {31'h0, channel_done_irq[b]});
	endtask : wait_irq
	// one width measurement with a start attempt mid-pulse
	task automatic meas(input logic [15:0] m, input logic v, input int w,
		input logic [31:0] ed, input logic [31:0] es);
		apb(1'b1, OFS_STOP, 32'h1);
		apb(1'b1, OFS_MODE_MEAS, {16'h0, m});
		u_src.park(!v);
		apb(1'b1, OFS_START, 32'h1);
		fork
			u_src.pulse(v, w);
			wait_irq(0, w + 300);
			begin
				repeat (w / 2) @(posedge pclk);
				apb(1'b1, OFS_START, 32'h1);
			end
		join
		rdchk(OFS_DATA, ed, "data");
		rdchk(OFS_STATUS, es, "overflow");
		rdchk(OFS_COUNTER, ed + 1, "counter");
	endtask : meas

	initial begin
		{psel, penable, pwrite, paddr, pwdata, presetn} = '0;
		pstrb = 4'hF;
		{mismatches, checks_done, cycles, seen_hi} = '0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rst_a[k]) rdchk(rst_a[k], 32'h0, "reset value");
		apb(1'b0, 8'h3C, 32'h0);
		chk("slverr", 32'h1, {31'h0, err});
		chk("unmapped", 32'h0, rd);
		pstrb <= 4'h1;
		apb(1'b1, OFS_SLAVE_DATA, 32'h0000ABCD);
		pstrb <= 4'hF;
		rdchk(OFS_SLAVE_DATA, 32'h000000CD, "lane strobe");
		apb(1'b1, OFS_OUT_LEVEL, 32'h1);
		repeat (3) @(posedge pclk);
		chk("pin0", 32'h1, {31'h0, timer_output_pin[0]});
		apb(1'b1, OFS_OUT_LEVEL, 32'h0);
		apb(1'b1, OFS_MODE_SLAVE, 32'h0409);
		apb(1'b1, OFS_SLAVE_DATA, 32'd200);
		apb(1'b1, OFS_OUT_ENABLE, 32'h2);
		apb(1'b1, OFS_OUT_MODE, 32'h2);
		apb(1'b1, OFS_START, 32'h2);
		meas(16'h00C0, 1'b1, 30, 32'd29, 32'h0);
		rdchk(OFS_ENABLED, 32'h3, "enabled");
		wait_irq(1, 400);
		rdchk(OFS_SLAVE_COUNT, 32'h0000FFFF, "slave count");
		chk("slave out high", 32'h1, {31'h0, seen_hi});
		chk("slave out low", 32'h0, {31'h0, timer_output_pin[1]});
		apb(1'b1, OFS_OUT_LEVEL, 32'h2);
		rdchk(OFS_OUT_LEVEL, 32'h0, "level locked");
		apb(1'b1, OFS_MODE_SLAVE, 32'h0009);
		apb(1'b1, OFS_SLAVE_DATA, 32'd50);
		apb(1'b1, OFS_START, 32'h2);
		apb(1'b1, OFS_START, 32'h2);
		rdchk(OFS_SLAVE_COUNT, 32'd49, "retrigger");
		wait_irq(1, 200);
		apb(1'b1, OFS_STOP, 32'h3);
		meas(16'h0080, 1'b0, 17, 32'd16, 32'h0);
		apb(1'b1, OFS_PRESCALE, 32'h10);
		meas(16'h80C0, 1'b1, 24, 32'd11, 32'h0);
		apb(1'b1, OFS_PRESCALE, 32'h0);
		meas(16'h00C0, 1'b1, 65546, 32'd9, 32'h1);
		meas(16'h00C0, 1'b1, 5, 32'd4, 32'h0);
		apb(1'b1, OFS_OUT_POLARITY, 32'h2);
		repeat (3) @(posedge pclk);
		chk("pins", 32'h2, {30'h0, timer_output_pin});
		stop_test();
	end
endmodule : tb_top

bind tpw_timer tpw_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_input_pin(timer_input_pin),
	.timer_output_pin(timer_output_pin), .channel_done_irq(channel_done_irq));
